// file: pkg/dnc_pkg.sv
// Shared constants for the drive network control word bank.
package dnc_pkg;

  // ----------------------------------------------------------------
  // Parameter numbers used to reach each word over the parameter port
  // ----------------------------------------------------------------
  localparam logic [9:0] DNC_NUM_STATE    = 10'h2a8; // Drive state word, read only.
  localparam logic [9:0] DNC_NUM_SPEED    = 10'h2a9; // Speed monitor word, read only.
  localparam logic [9:0] DNC_NUM_COMMAND  = 10'h2aa; // Network command word.
  localparam logic [9:0] DNC_NUM_SETPOINT = 10'h2ab; // Network speed setpoint.

  // ----------------------------------------------------------------
  // Field positions of the drive state word (upper bits)
  // ----------------------------------------------------------------
  localparam int DNC_ST_LOW_W    = 11;  // Bits 0 to 10 come from the drive core as they are.
  localparam int DNC_ST_INCHING  = 11;
  localparam int DNC_ST_REMOTE   = 12;
  localparam int DNC_ST_UNDERVOLT = 13;
  localparam int DNC_ST_PID_AUTO = 14;
  localparam int DNC_ST_FAULT    = 15;

  // ----------------------------------------------------------------
  // Field positions of the network command word
  // ----------------------------------------------------------------
  localparam int DNC_CMD_RUN      = 0;
  localparam int DNC_CMD_ENABLE   = 1;
  localparam int DNC_CMD_DIR      = 2;
  localparam int DNC_CMD_INCHING  = 3;
  localparam int DNC_CMD_REMOTE   = 4;
  localparam int DNC_CMD_RAMP2    = 5;
  localparam int DNC_CMD_QSTOP    = 6;
  localparam int DNC_CMD_FRESET   = 7;
  localparam int DNC_CMD_LIVE_W   = 8;  // Bits 8 to 15 are reserved.

  // ----------------------------------------------------------------
  // Widths, reset values and speed scale
  // ----------------------------------------------------------------
  localparam int               DNC_WORD_W       = 16;
  localparam int               DNC_SPEED_IN_W   = 20; // Speed magnitude from the core, 13-bit scale.
  localparam logic [15:0]      DNC_WORD_RESET   = 16'h0000;
  localparam logic [7:0]       DNC_CMD_RESET    = 8'h00;
  localparam logic signed [15:0] DNC_SPEED_RATED = 16'sh2000; // Rated frequency on the 13-bit scale.
  localparam logic signed [20:0] DNC_SAT_MAX    = 21'sh007fff; // Saturation ceiling, 32767.
  localparam logic signed [20:0] DNC_SAT_MIN    = -21'sh008000; // Saturation floor, -32768.

endpackage

// file: hw/dnc_speed_sat.sv
// Signed speed saturation from the core's wide value to a 16-bit network word.
`timescale 1ns/1ps

module dnc_speed_sat
  import dnc_pkg::*;
(
  input  wire logic [dnc_pkg::DNC_SPEED_IN_W-1:0] i_mag,      // Speed magnitude, 13-bit scale.
  input  wire logic                               i_reverse,  // High while turning in reverse.
  output logic signed [15:0]                      o_word      // Signed, saturated speed word.
);

  logic signed [20:0] signed_val;

  // ----------------------------------------------------------------
  // Sign and clamp
  // ----------------------------------------------------------------
  // reverse gives negative
  // The magnitude is widened by one bit first so negation never overflows.
  always_comb begin
    if (i_reverse) begin
      signed_val = -$signed({1'b0, i_mag});
    end else begin
      signed_val = $signed({1'b0, i_mag});
    end
  end

  // clamp not wrap
  // A wrap would flip the sign seen by the master, so we pin to the rails.
  always_comb begin
    if (signed_val > DNC_SAT_MAX) begin
      o_word = DNC_SAT_MAX[15:0];
    end else if (signed_val < DNC_SAT_MIN) begin
      o_word = DNC_SAT_MIN[15:0];
    end else begin
      o_word = signed_val[15:0];
    end
  end

endmodule

// file: hw/dnc_words.sv
// Network-facing status, speed, command and setpoint words of the drive.
`timescale 1ns/1ps

// What this block does
// - State word bit 11 shows whether the inching function is active.
// - State word bit 12 shows remote (1) or local (0) mode.
// - State word bit 13 shows an undervoltage condition.
// - State word bit 14 shows process controller automatic (1) or manual (0).
// - State word bit 15 shows a detected fault; number lives elsewhere.
// - Speed monitor word is signed, 8192 equals rated frequency, linear.
// - Speed monitor word is negative while the motor turns in reverse.
// - Network speed values saturate at 32767 and -32768, never wrap.
// - Command word is writable only from the serial interface.
// - Commands act only when serial command source is selected, except bit 2, which sets the direction output from any source.
// - Command bit 0 runs up the ramp or stops along it.
// - Command bit 1 enables the drive or cuts motor power.
// - Command bit 2 keeps or inverts the reference direction.
// - Command bit 3 enables or disables the inching function.
// - Command bit 4 requests remote or local mode.
// - Command bit 5 picks second or first ramp time pair.
// - Command bit 6 quick stops, not allowed in scalar or vector-voltage control.
// - Command bit 7 resets a present fault; zero does nothing.
// - Command word resets to zero; bits 8 to 15 carry no command.
// - Speed setpoint is signed, serial-writable only, resets to zero.
// - Serial setpoint is used as reference only when the active source selects it; its sign sets the direction output from any source.
// - Setpoint uses the signed 13-bit scale, 8192 equals rated frequency.
// - Direction is forward when bit 2 agrees with a positive setpoint.
module dnc_words
  import dnc_pkg::*;
(
  input  wire logic                               i_clk,            // Clock, 100 MHz.
  input  wire logic                               i_rst,            // Synchronous reset, active high.
  // Parameter access port.
  input  wire logic                               i_wr_en,          // Write request strobe.
  input  wire logic                               i_rd_en,          // Read request strobe.
  input  wire logic                               i_src_serial,     // Request comes from the serial link.
  input  wire logic [9:0]                         i_num,            // Parameter number.
  input  wire logic [15:0]                        i_wdata,          // Write data.
  output logic [15:0]                             o_rdata,          // Read data, registered.
  output logic                                    o_ack,            // Request accepted, one cycle.
  output logic                                    o_refused,        // Request refused, one cycle.
  // Drive core state.
  input  wire logic [dnc_pkg::DNC_ST_LOW_W-1:0]   i_status_low,     // State bits 0 to 10.
  input  wire logic                               i_inching_active, // Inching function running.
  input  wire logic                               i_remote_mode,    // Drive is in remote mode.
  input  wire logic                               i_undervoltage,   // Undervoltage present.
  input  wire logic                               i_pid_auto,       // Process controller automatic.
  input  wire logic                               i_fault,          // A fault is present.
  input  wire logic [dnc_pkg::DNC_SPEED_IN_W-1:0] i_speed_mag,      // Speed magnitude, 13-bit scale.
  input  wire logic                               i_motor_reverse,  // Motor turning in reverse.
  // Configuration.
  input  wire logic                               i_cmd_src_serial, // Commands taken from serial.
  input  wire logic                               i_ref_serial_loc, // Local reference source is serial.
  input  wire logic                               i_ref_serial_rem, // Remote reference source is serial.
  input  wire logic                               i_ctrl_no_qstop,  // Scalar or vector-voltage control.
  // Command outputs to the drive core.
  output logic                                    o_run,            // Run up the ramp, else ramp stop.
  output logic                                    o_enable,         // Drive enabled for the motor.
  output logic                                    o_dir_fwd,        // Effective direction forward.
  output logic                                    o_inching,        // Inching function enabled.
  output logic                                    o_remote_req,     // Remote mode requested.
  output logic                                    o_ramp_second,    // Use second ramp time pair.
  output logic                                    o_quick_stop,     // Quick stop requested.
  output logic                                    o_fault_reset,    // Fault reset, one-cycle pulse.
  output logic                                    o_cmd_active,     // Serial command set is in force.
  output logic                                    o_ref_active,     // Serial setpoint is in force.
  output logic signed [15:0]                      o_speed_ref       // Setpoint, 13-bit scale.
);

  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  logic [DNC_CMD_LIVE_W-1:0] cmd_ff;
  logic signed [15:0]        setpoint_ff;
  logic signed [15:0]        speed_word;
  logic [15:0]               state_word;
  logic                      hit_state;
  logic                      hit_speed;
  logic                      hit_cmd;
  logic                      hit_set;
  logic                      hit_any;
  logic                      wr_ok;
  logic                      wr_cmd;
  logic                      wr_set;
  logic                      ref_sel;
  logic [15:0]               nxt_rdata;

  assign hit_state = (i_num == DNC_NUM_STATE);
  assign hit_speed = (i_num == DNC_NUM_SPEED);
  assign hit_cmd   = (i_num == DNC_NUM_COMMAND);
  assign hit_set   = (i_num == DNC_NUM_SETPOINT);
  assign hit_any   = hit_state | hit_speed | hit_cmd | hit_set;

  // serial-only command writes
  // Other sources see both writable words as read only and get a refusal.
  assign wr_ok  = i_wr_en & i_src_serial & (hit_cmd | hit_set);
  assign wr_cmd = wr_ok & hit_cmd;
  assign wr_set = wr_ok & hit_set;

  always_comb begin
    state_word                   = {i_fault, i_pid_auto, i_undervoltage, i_remote_mode, i_inching_active,
                                    i_status_low};
    state_word[DNC_ST_INCHING]   = i_inching_active;
    state_word[DNC_ST_REMOTE]    = i_remote_mode;
    state_word[DNC_ST_UNDERVOLT] = i_undervoltage;
    state_word[DNC_ST_PID_AUTO]  = i_pid_auto;
    state_word[DNC_ST_FAULT]     = i_fault;
  end

  // signed speed monitor
  // The leaf clamps the core's wide value to the 16-bit word.
  dnc_speed_sat u_sat (
    .i_mag     (i_speed_mag),
    .i_reverse (i_motor_reverse),
    .o_word    (speed_word)
  );

  // ----------------------------------------------------------------
  // Writable words
  // ----------------------------------------------------------------
  // command word reset zero
  // reserved bits dropped
  // Only the eight live bits are stored, so reserved writes cannot leak anywhere.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_ff <= DNC_CMD_RESET;
    end else if (wr_cmd) begin
      cmd_ff <= i_wdata[DNC_CMD_LIVE_W-1:0];
    end
  end

  // setpoint stored as scaled
  // The value is kept as written; the scale is the drive core's to apply.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      setpoint_ff <= DNC_WORD_RESET;
    end else if (wr_set) begin
      setpoint_ff <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read and answer path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = DNC_WORD_RESET;
    if (hit_state) begin
      nxt_rdata = state_word;
    end else if (hit_speed) begin
      nxt_rdata = speed_word;
    end else if (hit_cmd) begin
      nxt_rdata = {{(DNC_WORD_W-DNC_CMD_LIVE_W){1'b0}}, cmd_ff};
    end else if (hit_set) begin
      nxt_rdata = setpoint_ff;
    end
  end

  // A read holds its data until the next accepted read, so a slow master need not hurry.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= DNC_WORD_RESET;
    end else if (i_rd_en && hit_any) begin
      o_rdata <= nxt_rdata;
    end
  end

  // Answer one cycle after the strobe; a write wins when both strobes come together.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ack     <= 1'b0;
      o_refused <= 1'b0;
    end else if (i_wr_en) begin
      o_ack     <= wr_ok;
      o_refused <= ~wr_ok;
    end else begin
      o_ack     <= i_rd_en & hit_any;
      o_refused <= i_rd_en & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // Command outputs to the drive core
  // ----------------------------------------------------------------
  // commands gated by source
  // ramp pair select
  // When serial is not the command source every output drops to its idle level.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cmd_active  <= 1'b0;
      o_run         <= 1'b0;
      o_enable      <= 1'b0;
      o_inching     <= 1'b0;
      o_remote_req  <= 1'b0;
      o_ramp_second <= 1'b0;
    end else begin
      o_cmd_active  <= i_cmd_src_serial;
      o_run         <= i_cmd_src_serial & cmd_ff[DNC_CMD_RUN];
      o_enable      <= i_cmd_src_serial & cmd_ff[DNC_CMD_ENABLE];
      o_inching     <= i_cmd_src_serial & cmd_ff[DNC_CMD_INCHING];
      o_remote_req  <= i_cmd_src_serial & cmd_ff[DNC_CMD_REMOTE];
      o_ramp_second <= i_cmd_src_serial & cmd_ff[DNC_CMD_RAMP2];
    end
  end

  // quick stop blocked by control type
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_quick_stop <= 1'b0;
    end else begin
      o_quick_stop <= i_cmd_src_serial & cmd_ff[DNC_CMD_QSTOP] & ~i_ctrl_no_qstop;
    end
  end

  // fault reset pulse
  // Issued once per write carrying bit 7, so a stuck bit does not reset again and again.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_reset <= 1'b0;
    end else begin
      o_fault_reset <= wr_cmd & i_wdata[DNC_CMD_FRESET] & i_fault & i_cmd_src_serial;
    end
  end

  // setpoint source select
  // The situation that counts is the present local or remote mode.
  assign ref_sel = i_remote_mode ? i_ref_serial_rem : i_ref_serial_loc;

  // direction from bit and sign
  // A zero setpoint counts as positive, so bit 2 alone decides its direction.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ref_active <= 1'b0;
      o_speed_ref  <= DNC_WORD_RESET;
      o_dir_fwd    <= 1'b0;
    end else begin
      o_ref_active <= ref_sel;
      o_speed_ref  <= ref_sel ? setpoint_ff : DNC_WORD_RESET;
      o_dir_fwd    <= cmd_ff[DNC_CMD_DIR] ? ~setpoint_ff[DNC_WORD_W-1] : setpoint_ff[DNC_WORD_W-1];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_state_fault_bit: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && !i_wr_en && hit_state) |=> (o_rdata[DNC_ST_FAULT] == $past(i_fault) && o_ack))
    else $error("Fault bit of state word read back wrong.");

  a_state_mode_bits: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && !i_wr_en && hit_state) |=>
      (o_rdata[DNC_ST_REMOTE] == $past(i_remote_mode) && o_rdata[DNC_ST_INCHING] == $past(i_inching_active)))
    else $error("Mode bits of state word read back wrong.");

  a_speed_sign_rev: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && !i_wr_en && hit_speed && i_motor_reverse && i_speed_mag != '0) |=> o_rdata[DNC_WORD_W-1])
    else $error("Reverse speed did not read negative.");

  a_speed_sat_top: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && !i_wr_en && hit_speed && !i_motor_reverse && i_speed_mag[DNC_SPEED_IN_W-1])
      |=> (o_rdata == DNC_SAT_MAX[15:0]))
    else $error("Speed word did not saturate at the top.");

  a_cmd_serial_only: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && !i_src_serial && hit_cmd) |=> ($stable(cmd_ff) && o_refused && !o_ack))
    else $error("Non-serial write changed the command word.");

  a_cmd_reserved_z: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && !i_wr_en && hit_cmd) |=> (o_rdata[15:DNC_CMD_LIVE_W] == '0))
    else $error("Reserved command bits read nonzero.");

  a_run_follows_cmd: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr_cmd && i_cmd_src_serial) ##1 i_cmd_src_serial |=> (o_run == $past(i_wdata[DNC_CMD_RUN], 2)))
    else $error("Run output did not follow command bit 0.");

  a_gate_by_source: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_cmd_src_serial |=> !(o_run || o_enable || o_inching || o_remote_req || o_quick_stop))
    else $error("Command output active without serial source.");

  a_qstop_blocked: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_ctrl_no_qstop |=> !o_quick_stop)
    else $error("Quick stop in a control type that forbids it.");

  a_freset_pulse: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_fault_reset |-> ($past(wr_cmd) && $past(i_fault) && $past(i_wdata[DNC_CMD_FRESET]))
      ##1 (!o_fault_reset || $past(wr_cmd)))
    else $error("Fault reset pulse without cause or too long.");

  a_setpoint_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && !i_src_serial && hit_set) |=> $stable(setpoint_ff))
    else $error("Non-serial write changed the setpoint.");

  a_ref_source: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!i_remote_mode && !i_ref_serial_loc) |=> (!o_ref_active && o_speed_ref == DNC_WORD_RESET))
    else $error("Serial setpoint used with another local source.");

  a_direction_map: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cmd_ff[DNC_CMD_DIR] && setpoint_ff < 0) |=> !o_dir_fwd)
    else $error("Direction wrong for bit 2 set and negative setpoint.");

  a_cmd_reset_zero: assert property (
    @(posedge i_clk) $fell(i_rst) |-> (cmd_ff == DNC_CMD_RESET && setpoint_ff == DNC_WORD_RESET))
    else $error("Writable words not zero after reset.");

  a_enable_follows: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_cmd_src_serial |=> (o_enable == $past(cmd_ff[DNC_CMD_ENABLE])))
    else $error("Enable output did not follow command bit 1.");

  a_ramp_pair_sel: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_cmd_src_serial |=> (o_ramp_second == $past(cmd_ff[DNC_CMD_RAMP2])))
    else $error("Ramp pair output did not follow command bit 5.");

  a_ref_remote_use: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_remote_mode && i_ref_serial_rem) |=> (o_ref_active && o_speed_ref == $past(setpoint_ff)))
    else $error("Serial setpoint not used with serial remote source.");

  c_serial_cmd_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_cmd ##1 o_ack);
  c_refused_write: cover property (@(posedge i_clk) disable iff (i_rst) i_wr_en && !i_src_serial ##1 o_refused);
  c_fault_reset: cover property (@(posedge i_clk) disable iff (i_rst) o_fault_reset);
  c_reverse_speed: cover property (@(posedge i_clk) disable iff (i_rst) i_rd_en && hit_speed && i_motor_reverse);

endmodule

// file: tb/dnc_master_model.sv
// Serial master model that issues parameter reads and writes to the word bank.
`timescale 1ns/1ps

module dnc_master_model (
  input  wire logic        i_clk,     // Bench clock.
  input  wire logic        i_ack,     // Accept pulse from the bank.
  input  wire logic        i_refused, // Refuse pulse from the bank.
  output logic             o_wr_en,   // Write strobe.
  output logic             o_rd_en,   // Read strobe.
  output logic             o_serial,  // Request comes from the serial link.
  output logic [9:0]       o_num,     // Parameter number.
  output logic [15:0]      o_wdata    // Write data.
);
  // Idle values before the first request.
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_serial = 1'b0;
    o_num = 10'h000;
    o_wdata = 16'h0000;
  end

  // One request: raised after a falling edge, answer sampled one cycle later.
  // Released number and data lines show the inverse so that stale data is never mistaken for valid data.
  task automatic access(input logic wr, input logic ser, input logic [9:0] num, input logic [15:0] wd,
                        output logic ack, output logic rfs);
    @(negedge i_clk);
    o_wr_en = wr;
    o_rd_en = ~wr;
    o_serial = ser;
    o_num = num;
    o_wdata = wd;
    @(negedge i_clk);
    ack = i_ack;
    rfs = i_refused;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_num = ~num;
    o_wdata = ~wd;
  endtask
endmodule

// file: tb/dnc_words_test.sv
// Self-checking bench for the drive network word bank.
`timescale 1ns/1ps

module dnc_words_test;
  import dnc_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, wr_en, rd_en, src_ser, ack, refused, inch, rem, uv, pid, flt, rev;
  logic cmd_src, ref_loc, ref_rem, no_qs, run, en, dir, inching_function, rreq, r2, qs, frst, cact, ract, a, f;
  logic [9:0] num;
  logic [15:0] wdata, rdata;
  logic [10:0] st_low;
  logic [19:0] mag;
  logic signed [15:0] sref;
  logic [31:0] lfsr = 32'hea54;
  int error_cnt = 0, checks = 0, cyc = 0;

  always #5 i_clk = ~i_clk;

  dnc_master_model master (.i_clk(i_clk), .i_ack(ack), .i_refused(refused), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_serial(src_ser), .o_num(num), .o_wdata(wdata));

  dnc_words uut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_src_serial(src_ser),
    .i_num(num), .i_wdata(wdata), .o_rdata(rdata), .o_ack(ack), .o_refused(refused), .i_status_low(st_low),
    .i_inching_active(inch), .i_remote_mode(rem), .i_undervoltage(uv), .i_pid_auto(pid), .i_fault(flt),
    .i_speed_mag(mag), .i_motor_reverse(rev), .i_cmd_src_serial(cmd_src), .i_ref_serial_loc(ref_loc),
    .i_ref_serial_rem(ref_rem), .i_ctrl_no_qstop(no_qs), .o_run(run), .o_enable(en), .o_dir_fwd(dir),
    .o_inching(inching_function), .o_remote_req(rreq), .o_ramp_second(r2), .o_quick_stop(qs), .o_fault_reset(frst),
    .o_cmd_active(cact), .o_ref_active(ract), .o_speed_ref(sref));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs about 1060 cycles; a stuck handshake ends it here.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int m_cmd, m_sp, sv, i;
    logic ser, ser2;
    logic [15:0] w1, w2;
    logic [19:0] edge_mag [4];
    edge_mag = '{20'h00000, 20'h02000, 20'h07fff, 20'h08000};
    m_cmd = 0;
    m_sp = 0;
    {st_low, inch, rem, uv, pid, flt, mag, rev, cmd_src, ref_loc, ref_rem, no_qs} = '0;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    master.access(1'b0, 1'b1, DNC_NUM_COMMAND, 16'h0000, a, f);
    chk(rdata, 16'h0000);
    master.access(1'b1, 1'b1, DNC_NUM_SPEED, 16'h1234, a, f);
    chk({14'h0, a, f}, 16'h0001);
    master.access(1'b0, 1'b1, 10'h3ff, 16'h0000, a, f);
    chk({14'h0, a, f}, 16'h0001);
    for (i = 0; i < 80; i++) begin
      // Mid-run reset must clear both writable words again.
      if (i == 40) begin
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        m_cmd = 0;
        m_sp = 0;
      end
      lfsr = lfsr_next(lfsr);
      {st_low, inch, rem, uv, pid, flt} = lfsr[15:0];
      {rev, cmd_src, ref_loc, ref_rem, no_qs, ser, ser2} = lfsr[22:16];
      mag = (i < 4) ? edge_mag[i] : (lfsr[31:12] >> lfsr[26:24]);
      w1 = lfsr[23:8] ^ {lfsr[7:0], lfsr[15:8]};
      w2 = lfsr[31:16];
      master.access(1'b0, 1'b0, DNC_NUM_STATE, 16'h0000, a, f);
      chk(rdata, {flt, pid, uv, rem, inch, st_low});
      chk({14'h0, a, f}, 16'h0002);
      master.access(1'b0, 1'b0, DNC_NUM_SPEED, 16'h0000, a, f);
      sv = rev ? -int'(mag) : int'(mag);
      sv = (sv > 32767) ? 32767 : ((sv < -32768) ? -32768 : sv);
      chk(rdata, 16'(sv));
      master.access(1'b1, ser, DNC_NUM_COMMAND, w1, a, f);
      chk({13'h0, a, f, frst}, {13'h0, ser, ~ser, ser & w1[7] & flt & cmd_src});
      m_cmd = ser ? int'(w1[7:0]) : m_cmd;
      master.access(1'b1, ser2, DNC_NUM_SETPOINT, w2, a, f);
      chk({14'h0, a, f}, {14'h0, ser2, ~ser2});
      m_sp = ser2 ? int'($signed(w2)) : m_sp;
      master.access(1'b0, 1'b0, DNC_NUM_COMMAND, 16'h0000, a, f);
      chk(rdata, 16'(m_cmd));
      master.access(1'b0, 1'b0, DNC_NUM_SETPOINT, 16'h0000, a, f);
      chk(rdata, 16'(m_sp));
      @(negedge i_clk);
      chk({9'h0, run, en, inching_function, rreq, r2, qs, cact}, {9'h0, {6{cmd_src}} & {m_cmd[0], m_cmd[1], m_cmd[3], m_cmd[4],
          m_cmd[5], m_cmd[6] & ~no_qs}, cmd_src});
      chk({14'h0, dir, ract}, {14'h0, m_cmd[2] ? (m_sp >= 0) : (m_sp < 0), rem ? ref_rem : ref_loc});
      chk(sref, (rem ? ref_rem : ref_loc) ? 16'(m_sp) : 16'h0000);
    end
    report_and_stop();
  end
endmodule
